// ==== verilog/at_cmd_pkg.sv ====
// shared constants and carrier types for the serial at-command decoder
package at_cmd_pkg;
  // register byte offsets
  localparam logic [7:0] CONFIG_OFS = 8'h00;
  localparam logic [7:0] STORED_PROG_OFS = 8'h04;
  localparam logic [7:0] STORED_BLOCK_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] LAST_ERR_OFS = 8'h10;
  // config field positions
  localparam int CFG_AUTH_BIT = 0;
  localparam int CFG_ABS_DEP_BIT = 1;
  localparam int CFG_ABS_DEF_BIT = 2;
  localparam int CFG_DIR_DEP_BIT = 3;
  localparam int CFG_DIR_DEF_LSB = 4;
  localparam int CFG_PWRUP_BIT = 6;
  localparam int CFG_MULTI_BIT = 7;
  localparam int CFG_ID_LSB = 8;
  localparam int CFG_W = 12;
  localparam logic [11:0] CONFIG_RST = 12'h100;
  localparam logic [15:0] STORED_PROG_RST = 16'h0000;
  localparam logic [15:0] STORED_BLOCK_RST = 16'h0000;
  localparam logic [15:0] FIRST_BLOCK = 16'h0000;
  // characters
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_KEY = 8'h21;
  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] MAX_LEN = 8'h80;
  // command numbers
  localparam logic [7:0] CMD_ABORT = 8'h01;
  localparam logic [7:0] CMD_STOP = 8'h02;
  localparam logic [7:0] CMD_START = 8'h03;
  localparam logic [7:0] CMD_ERR_RESET = 8'h04;
  localparam logic [7:0] CMD_SERVO = 8'h08;
  localparam logic [7:0] CMD_M_ANSWER = 8'h09;
  localparam logic [7:0] CMD_HOME_OFS = 8'h0A;
  localparam logic [7:0] CMD_JOG = 8'h0B;
  localparam logic [7:0] CMD_INTEGRAL = 8'h0C;
  localparam logic [7:0] CMD_COORD = 8'h0D;
  // start actions
  localparam logic [3:0] ACT_TEST = 4'h0;
  localparam logic [3:0] ACT_TUNE = 4'h1;
  localparam logic [3:0] ACT_HOME = 4'h3;
  localparam logic [3:0] ACT_PROGRAM = 4'h4;
  localparam logic [3:0] ACT_SEARCH = 4'h6;
  localparam logic [3:0] ACT_MANUAL = 4'h7;
  localparam logic [3:0] ACT_INDEX_A = 4'h8;
  localparam logic [3:0] ACT_INDEX_B = 4'h9;
  localparam logic [3:0] ACT_TABLE = 4'hA;
  localparam logic [3:0] ACT_MECH = 4'hF;
  localparam logic [1:0] DIR_NEAREST = 2'h0;
  localparam logic [1:0] DIR_NO_HOME_CROSS = 2'h1;
  localparam logic [1:0] DIR_FROM_HOME = 2'h2;
  // error codes, arbitrary values
  localparam logic [7:0] ERR_AUTH = 8'h41;
  localparam logic [7:0] ERR_BUSY = 8'h42;
  localparam logic [7:0] ERR_FORMAT = 8'h43;
  localparam logic [3:0] ERR_SUB = 4'h0;
  typedef enum logic [2:0] {P_IDLE, P_KEY, P_CMD, P_FLD, P_SKIP} parse_t;
  typedef struct packed {
    logic is_err;
    logic [3:0] keys;
    logic [7:0] err_main;
    logic [3:0] err_sub;
  } reply_t;
  typedef struct packed {
    logic [7:0] cmd;
    logic [2:0] nf;
    logic [3:0] action;
    logic [31:0] p1;
    logic [31:0] p2;
    logic abs_move;
    logic [1:0] dir_type;
  } cmd_out_t;
endpackage : at_cmd_pkg

// ==== verilog/servo_at_command_decoder.sv ====
// serial at-command decoder: parses, gates and dispatches operating commands
`timescale 1ns/1ps
// Contract
// - commands needing authority are refused unless serial link holds it
// - servo command 8 accepted only under serial authority
// - servo field 1 requests on, 0 requests off
// - servo on only if request, controller enable and panel permit all hold
// - power-up servo request taken from stored configuration bit
// - servo command replies at once, not waiting for servo ready
// - start command 3 needs serial authority and idle driver
// - start reply withheld until operation completes
// - actions 0,1,3,6,7,15 take exactly one field
// - action 4 takes one to three fields, 8,9,10 two to four
// - program number alone runs that program from first block
// - program start with no options resumes stored program and block
// - program and block number run program from given block; blocks above 1 are refused under abs/inc option dependence
// - index number is offset if incremental, target if absolute
// - second index option 0 incremental, 1 absolute
// - second option ignored unless absolute/incremental set to option dependence
// - dependence with second option absent means incremental
// - third option values 0,1,2 map to direction types 0,1,2
// - third option ignored unless dependence; absent means type 0
// - direction type passed on: nearest, no home cross, from home
// - frames end in CR, at most 128 chars, station id prefix in multi mode
// - reply echoes key count modulo 16
// - reply is normal with no fields or error with main and sub code
module servo_at_command_decoder #(
  parameter int NUM_W = 32
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic drive_idle_i,
  input wire logic op_done_i,
  input wire logic [31:0] current_cmd_i,
  input wire logic plc_servo_enable_i,
  input wire logic panel_servo_inhibit_switch_i,
  output logic servo_on_o,
  output logic reply_valid_o,
  output at_cmd_pkg::reply_t reply_o,
  output logic cmd_valid_o,
  output at_cmd_pkg::cmd_out_t cmd_o
);
  // the field and accumulator logic is written for 32-bit numbers only
  if (NUM_W != 32) begin : g_num_w_check
    $error("NUM_W must be 32");
  end

  typedef struct packed {
    at_cmd_pkg::parse_t pst;
    logic [3:0] keys;
    logic [7:0] len;
    logic [7:0] cmd;
    logic [2:0] nf;
    logic [3:0][31:0] fld;
    logic [31:0] acc;
    logic neg;
    logic dig;
    logic fmt_err;
    logic init_done;
    logic servo_req;
    logic en_s1;
    logic en_s2;
    logic inh_s1;
    logic inh_s2;
    logic servo_on;
    logic pend;
    logic pend_done;
    logic [3:0] pend_keys;
    logic reply_valid;
    at_cmd_pkg::reply_t reply;
    logic cmd_valid;
    at_cmd_pkg::cmd_out_t cmd_out;
    logic [11:0] cfg;
    logic [15:0] sprog;
    logic [15:0] sblk;
    logic [7:0] last_err;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  state_t st, nx;

  function automatic logic [31:0] mul10_add(input logic [31:0] a, input logic [7:0] c);
    logic [31:0] d;
    d = {24'h000000, c - at_cmd_pkg::CH_ZERO};
    return (a << 3) + (a << 1) + d;
  endfunction : mul10_add

  function automatic logic is_digit(input logic [7:0] c);
    return (c >= at_cmd_pkg::CH_ZERO) && (c <= 8'h39);
  endfunction : is_digit

  // field count allowed for each start action
  function automatic logic start_ok(input logic [3:0] act, input logic [2:0] n);
    case (act)
      at_cmd_pkg::ACT_TEST, at_cmd_pkg::ACT_TUNE, at_cmd_pkg::ACT_HOME,
      at_cmd_pkg::ACT_SEARCH, at_cmd_pkg::ACT_MANUAL, at_cmd_pkg::ACT_MECH:
        return n == 3'h1;
      at_cmd_pkg::ACT_PROGRAM: return (n >= 3'h1) && (n <= 3'h3);
      at_cmd_pkg::ACT_INDEX_A, at_cmd_pkg::ACT_INDEX_B, at_cmd_pkg::ACT_TABLE:
        return (n >= 3'h2) && (n <= 3'h4);
      default: return 1'b0;
    endcase
  endfunction : start_ok

  function automatic logic needs_auth(input logic [7:0] c);
    return (c == at_cmd_pkg::CMD_STOP) || (c == at_cmd_pkg::CMD_START)
        || (c == at_cmd_pkg::CMD_SERVO) || (c == at_cmd_pkg::CMD_JOG)
        || (c == at_cmd_pkg::CMD_INTEGRAL) || (c == at_cmd_pkg::CMD_COORD);
  endfunction : needs_auth

  logic auth;
  logic abs_dep;
  logic dir_dep;
  logic servo_hit;
  assign auth = st.cfg[at_cmd_pkg::CFG_AUTH_BIT];
  assign abs_dep = st.cfg[at_cmd_pkg::CFG_ABS_DEP_BIT];
  assign dir_dep = st.cfg[at_cmd_pkg::CFG_DIR_DEP_BIT];

  always_comb begin
    logic [7:0] c;
    logic [7:0] err;
    logic [7:0] adr;
    logic [31:0] rd;
    logic bad;
    logic immed;
    logic absv;
    logic [1:0] dirv;
    logic [3:0] act;
    at_cmd_pkg::parse_t ps;
    nx = st;
    c = rx_data_i;
    err = 8'h00;
    adr = paddr_i;
    rd = 32'h00000000;
    bad = 1'b0;
    immed = 1'b0;
    absv = 1'b0;
    dirv = at_cmd_pkg::DIR_NEAREST;
    act = st.fld[0][3:0];
    ps = st.pst;
    servo_hit = 1'b0;
    nx.reply_valid = 1'b0;
    nx.cmd_valid = 1'b0;
    // panel and controller levels are pins: two flops before use
    nx.en_s1 = plc_servo_enable_i;
    nx.en_s2 = st.en_s1;
    nx.inh_s1 = panel_servo_inhibit_switch_i;
    nx.inh_s2 = st.inh_s1;
    if (!st.init_done) begin
      nx.init_done = 1'b1;
      nx.servo_req = st.cfg[at_cmd_pkg::CFG_PWRUP_BIT];
    end
    nx.servo_on = st.servo_req & st.en_s2 & ~st.inh_s2;
    if (op_done_i && st.pend) begin
      nx.pend_done = 1'b1;
    end
    if (rx_valid_i) begin
      if (st.len != 8'hFF) begin
        nx.len = st.len + 8'h01;
      end
      // station prefix check in multi mode
      if (ps == at_cmd_pkg::P_IDLE && c != at_cmd_pkg::CH_CR) begin
        if (st.cfg[at_cmd_pkg::CFG_MULTI_BIT]) begin
          nx.pst = (c == at_cmd_pkg::CH_ZERO + {4'h0, st.cfg[11:8]})
                 ? at_cmd_pkg::P_KEY : at_cmd_pkg::P_SKIP;
        end else begin
          ps = at_cmd_pkg::P_KEY;
        end
      end
      if (c == at_cmd_pkg::CH_CR) begin
        if (ps == at_cmd_pkg::P_CMD) begin
          nx.cmd = st.acc[7:0];
          bad = !st.dig;
        end else if (ps == at_cmd_pkg::P_FLD) begin
          if (!st.dig || st.nf == 3'h4) begin
            bad = 1'b1;
          end else begin
            nx.fld[st.nf[1:0]] = st.neg ? (32'h00000000 - st.acc) : st.acc;
            nx.nf = st.nf + 3'h1;
          end
        end
        act = nx.fld[0][3:0];
        if (ps == at_cmd_pkg::P_CMD || ps == at_cmd_pkg::P_FLD
            || ps == at_cmd_pkg::P_KEY) begin
          immed = 1'b1;
          if (bad || st.fmt_err || ps == at_cmd_pkg::P_KEY || nx.len > at_cmd_pkg::MAX_LEN) begin
            err = at_cmd_pkg::ERR_FORMAT;
          end else if (needs_auth(nx.cmd) && !auth) begin
            err = at_cmd_pkg::ERR_AUTH;
          end else begin
            case (nx.cmd)
              at_cmd_pkg::CMD_SERVO: begin
                if (nx.nf != 3'h1 || nx.fld[0] > 32'h00000001) begin
                  err = at_cmd_pkg::ERR_FORMAT;
                end else begin
                  nx.servo_req = nx.fld[0][0];
                  servo_hit = 1'b1;
                end
              end
              at_cmd_pkg::CMD_START: begin
                if (!drive_idle_i || st.pend) begin
                  err = at_cmd_pkg::ERR_BUSY;
                end else if (!start_ok(act, nx.nf) || nx.fld[0][31:4] != 28'h0) begin
                  err = at_cmd_pkg::ERR_FORMAT;
                end else begin
                  absv = abs_dep ? 1'b0 : st.cfg[at_cmd_pkg::CFG_ABS_DEF_BIT];
                  dirv = dir_dep ? at_cmd_pkg::DIR_NEAREST : st.cfg[5:4];
                  if (abs_dep && nx.nf >= 3'h3) begin
                    absv = nx.fld[2][0];
                    if (nx.fld[2] > 32'h00000001) err = at_cmd_pkg::ERR_FORMAT;
                  end
                  if (dir_dep && nx.nf == 3'h4) begin
                    dirv = nx.fld[3][1:0];
                    if (nx.fld[3] > 32'h00000002) err = at_cmd_pkg::ERR_FORMAT;
                  end
                  nx.cmd_out.p1 = nx.fld[1];
                  nx.cmd_out.p2 = nx.fld[2];
                  if (act == at_cmd_pkg::ACT_PROGRAM) begin
                    if (nx.nf == 3'h1) begin
                      nx.cmd_out.p1 = {16'h0000, st.sprog};
                      nx.cmd_out.p2 = {16'h0000, st.sblk};
                    end else if (nx.nf == 3'h2) begin
                      nx.cmd_out.p2 = {16'h0000, at_cmd_pkg::FIRST_BLOCK};
                    end
                  end else if (act != at_cmd_pkg::ACT_TABLE) begin
                    nx.cmd_out.p2 = absv ? nx.fld[1] : current_cmd_i + nx.fld[1];
                  end
                  if (err == 8'h00) begin
                    immed = 1'b0;
                    nx.pend = 1'b1;
                    nx.pend_done = 1'b0;
                    nx.pend_keys = st.keys;
                    nx.cmd_valid = 1'b1;
                    nx.cmd_out.abs_move = absv;
                    nx.cmd_out.dir_type = dirv;
                  end
                end
              end
              at_cmd_pkg::CMD_ABORT, at_cmd_pkg::CMD_STOP, at_cmd_pkg::CMD_ERR_RESET,
              at_cmd_pkg::CMD_M_ANSWER, at_cmd_pkg::CMD_HOME_OFS, at_cmd_pkg::CMD_JOG,
              at_cmd_pkg::CMD_INTEGRAL, at_cmd_pkg::CMD_COORD: begin
                nx.cmd_valid = 1'b1;
                nx.cmd_out.p1 = nx.fld[0];
                nx.cmd_out.p2 = nx.fld[1];
                nx.cmd_out.abs_move = 1'b0;
                nx.cmd_out.dir_type = at_cmd_pkg::DIR_NEAREST;
              end
              default: err = at_cmd_pkg::ERR_FORMAT;
            endcase
          end
          nx.cmd_out.cmd = nx.cmd;
          nx.cmd_out.nf = nx.nf;
          nx.cmd_out.action = act;
        end
        // servo and other replies go out now
        if (immed) begin
          nx.reply_valid = 1'b1;
          // error carries codes, normal carries none
          nx.reply.is_err = err != 8'h00;
          nx.reply.err_main = err;
          nx.reply.err_sub = at_cmd_pkg::ERR_SUB;
          nx.reply.keys = st.keys;
          if (err != 8'h00) nx.last_err = err;
        end
        nx.pst = at_cmd_pkg::P_IDLE;
        nx.keys = 4'h0;
        nx.len = 8'h00;
        nx.nf = 3'h0;
        nx.acc = 32'h00000000;
        nx.neg = 1'b0;
        nx.dig = 1'b0;
        nx.fmt_err = 1'b0;
      end else begin
        case (ps)
          at_cmd_pkg::P_KEY: begin
            if (c == at_cmd_pkg::CH_KEY) begin
              nx.keys = st.keys + 4'h1;
              nx.pst = at_cmd_pkg::P_KEY;
            end else if (c == at_cmd_pkg::CH_AT) begin
              nx.pst = at_cmd_pkg::P_CMD;
            end else begin
              nx.fmt_err = 1'b1;
              nx.pst = at_cmd_pkg::P_KEY;
            end
          end
          at_cmd_pkg::P_CMD, at_cmd_pkg::P_FLD: begin
            if (is_digit(c)) begin
              nx.acc = mul10_add(st.acc, c);
              nx.dig = 1'b1;
            end else if (c == at_cmd_pkg::CH_MINUS && ps == at_cmd_pkg::P_FLD && !st.dig) begin
              nx.neg = 1'b1;
            end else if (c == at_cmd_pkg::CH_COLON && st.dig) begin
              if (ps == at_cmd_pkg::P_CMD) begin
                nx.cmd = st.acc[7:0];
              end else if (st.nf == 3'h4) begin
                nx.fmt_err = 1'b1;
              end else begin
                nx.fld[st.nf[1:0]] = st.neg ? (32'h00000000 - st.acc) : st.acc;
                nx.nf = st.nf + 3'h1;
              end
              nx.pst = at_cmd_pkg::P_FLD;
              nx.acc = 32'h00000000;
              nx.neg = 1'b0;
              nx.dig = 1'b0;
            end else begin
              nx.fmt_err = 1'b1;
            end
          end
          at_cmd_pkg::P_IDLE, at_cmd_pkg::P_SKIP: begin
          end
          default: nx.pst = at_cmd_pkg::P_IDLE;
        endcase
      end
    end
    // deferred start reply once completion is seen
    if (!immed && st.pend_done) begin
      nx.pend = 1'b0;
      nx.pend_done = 1'b0;
      nx.reply_valid = 1'b1;
      nx.reply.is_err = 1'b0;
      nx.reply.err_main = 8'h00;
      nx.reply.err_sub = at_cmd_pkg::ERR_SUB;
      nx.reply.keys = st.pend_keys;
    end
    // frame errors above must not leak into the bus error flag
    bad = 1'b0;
    // apb slave: one wait state, write lands on the completing edge
    case (adr)
      at_cmd_pkg::CONFIG_OFS: rd = {20'h00000, st.cfg};
      at_cmd_pkg::STORED_PROG_OFS: rd = {16'h0000, st.sprog};
      at_cmd_pkg::STORED_BLOCK_OFS: rd = {16'h0000, st.sblk};
      at_cmd_pkg::STATUS_OFS: rd = {27'h0000000, st.pend, st.inh_s2, st.en_s2,
                                    st.servo_on, st.servo_req};
      at_cmd_pkg::LAST_ERR_OFS: rd = {24'h000000, st.last_err};
      default: bad = 1'b1;
    endcase
    nx.pready = 1'b0;
    nx.pslverr = 1'b0;
    if (psel_i && penable_i && !st.pready) begin
      nx.pready = 1'b1;
      nx.prdata = (bad || pwrite_i) ? 32'h00000000 : rd;
      nx.pslverr = bad;
    end
    if (psel_i && penable_i && st.pready && pwrite_i && !st.pslverr) begin
      case (adr)
        at_cmd_pkg::CONFIG_OFS: nx.cfg = pwdata_i[11:0];
        at_cmd_pkg::STORED_PROG_OFS: nx.sprog = pwdata_i[15:0];
        at_cmd_pkg::STORED_BLOCK_OFS: nx.sblk = pwdata_i[15:0];
        default: nx.last_err = st.last_err;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
      st.pst <= at_cmd_pkg::P_IDLE;
      st.cfg <= at_cmd_pkg::CONFIG_RST;
      st.sprog <= at_cmd_pkg::STORED_PROG_RST;
      st.sblk <= at_cmd_pkg::STORED_BLOCK_RST;
    end else begin
      st <= nx;
    end
  end

  assign prdata_o = st.prdata;
  assign pready_o = st.pready;
  assign pslverr_o = st.pslverr;
  assign servo_on_o = st.servo_on;
  assign reply_valid_o = st.reply_valid;
  assign reply_o = st.reply;
  assign cmd_valid_o = st.cmd_valid;
  assign cmd_o = st.cmd_out;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_servo_and;
    servo_on_o |-> $past(st.servo_req && st.en_s2 && !st.inh_s2);
  endproperty
  a_servo_and: assert property (p_servo_and) else $error("servo on without all enables");

  property p_servo_off;
    $past(st.servo_req && st.en_s2 && !st.inh_s2) |-> servo_on_o;
  endproperty
  a_servo_off: assert property (p_servo_off) else $error("servo off despite all enables");

  property p_servo_auth;
    st.init_done && (nx.servo_req != st.servo_req) |-> auth;
  endproperty
  a_servo_auth: assert property (p_servo_auth) else $error("servo request without authority");

  property p_servo_reply;
    servo_hit |=> reply_valid_o && !reply_o.is_err;
  endproperty
  a_servo_reply: assert property (p_servo_reply) else $error("servo reply not immediate");

  property p_start_gate;
    cmd_valid_o && cmd_o.cmd == at_cmd_pkg::CMD_START |-> $past(drive_idle_i) && $past(auth);
  endproperty
  a_start_gate: assert property (p_start_gate) else $error("start accepted while busy");

  sequence s_start;
    cmd_valid_o && cmd_o.cmd == at_cmd_pkg::CMD_START;
  endsequence
  sequence s_done;
    st.pend ##0 op_done_i;
  endsequence

  property p_start_hold;
    s_start |-> !reply_valid_o;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start replied early");

  property p_done_reply;
    s_done |-> ##[1:4] (reply_valid_o && !reply_o.is_err);
  endproperty
  a_done_reply: assert property (p_done_reply) else $error("completion reply missing");

  property p_start_count;
    s_start |-> start_ok(cmd_o.action, cmd_o.nf);
  endproperty
  a_start_count: assert property (p_start_count) else $error("bad start accepted");

  property p_abs_default;
    s_start ##0 ($past(abs_dep) && cmd_o.nf < 3'h3) |-> !cmd_o.abs_move;
  endproperty
  a_abs_default: assert property (p_abs_default) else $error("absent option not incremental");

  property p_key_wrap;
    rx_valid_i && rx_data_i == at_cmd_pkg::CH_KEY && st.pst == at_cmd_pkg::P_KEY
      |=> st.keys == $past(st.keys) + 4'h1;
  endproperty
  a_key_wrap: assert property (p_key_wrap) else $error("key count wrong");
endmodule : servo_at_command_decoder

// ==== verif/host_model.sv ====
// host-side model that sends command strings one character per cycle
`timescale 1ns/1ps
module host_model (
  input wire logic clk_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'hA5;
  end
  task send(input string s);
    for (int i = 0; i <= s.len(); i++) begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o <= (i < s.len()) ? s[i] : at_cmd_pkg::CH_CR;
    end
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    // idle line flips so a stale character is never mistaken for data
    rx_data_o <= ~rx_data_o;
  endtask : send
endmodule : host_model

// ==== verif/tb_top.sv ====
// self-checking bench for the serial at-command decoder
`timescale 1ns/1ps
module tb_top;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, rx_valid, idle, op_done;
  logic plc, inhibit, servo_on, reply_valid, cmd_valid, re;
  logic [7:0] paddr, rx_data;
  logic [31:0] pwdata, prdata, cur, idx, rd;
  at_cmd_pkg::reply_t reply;
  at_cmd_pkg::cmd_out_t cmd;
  at_cmd_pkg::reply_t rq[$];
  at_cmd_pkg::cmd_out_t cq[$];
  int error_cnt, checks_done;
  string long_s;
  logic [3:0] acts[6] = '{4'h0, 4'h1, 4'h3, 4'h6, 4'h7, 4'hF};
  servo_at_command_decoder i_dut (.core_clk_i(core_clk), .nrst_i(nrst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rx_valid_i(rx_valid),
    .rx_data_i(rx_data), .drive_idle_i(idle), .op_done_i(op_done), .current_cmd_i(cur),
    .plc_servo_enable_i(plc), .panel_servo_inhibit_switch_i(inhibit), .servo_on_o(servo_on),
    .reply_valid_o(reply_valid), .reply_o(reply), .cmd_valid_o(cmd_valid), .cmd_o(cmd));
  host_model i_host (.clk_i(core_clk), .rx_valid_o(rx_valid), .rx_data_o(rx_data));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task finish_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task chk(input string n, input logic [95:0] e, input logic [95:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task cmp_reply(input at_cmd_pkg::reply_t e, input at_cmd_pkg::reply_t g);
    // a normal reply carries no codes, so those bits are not judged
    if (e.is_err === 1'b0) {g.err_main, g.err_sub} = 12'h000;
    chk("reply", e, g);
  endtask : cmp_reply
  task cmp_cmd(input at_cmd_pkg::cmd_out_t e, input at_cmd_pkg::cmd_out_t g);
    if (e.action < at_cmd_pkg::ACT_INDEX_A) {g.abs_move, g.dir_type} = 3'h0;
    if (e.nf == 3'h1 && e.action != at_cmd_pkg::ACT_PROGRAM) {g.p1, g.p2} = 64'h0;
    chk("cmd", e, g);
  endtask : cmp_cmd
  always @(posedge core_clk) begin
    if (reply_valid === 1'b1 && rq.size() == 0) chk("extra reply", 0, 1);
    else if (reply_valid === 1'b1) cmp_reply(rq.pop_front(), reply);
    if (cmd_valid === 1'b1 && cq.size() == 0) chk("extra cmd", 0, 1);
    else if (cmd_valid === 1'b1) cmp_cmd(cq.pop_front(), cmd);
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    re = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 20) begin
      chk("apb timeout", 0, 1);
      finish_test();
    end
  endtask : apb
  function automatic at_cmd_pkg::reply_t rp(input logic e, input logic [3:0] k,
                                            input logic [7:0] m);
    rp = '{is_err: e, keys: k, err_main: m, err_sub: at_cmd_pkg::ERR_SUB};
  endfunction : rp
  function automatic at_cmd_pkg::cmd_out_t cm(input logic [2:0] nf, input logic [3:0] act,
    input logic [31:0] p1, input logic [31:0] p2, input logic ab, input logic [1:0] dt);
    cm = '{cmd: at_cmd_pkg::CMD_START, nf: nf, action: act, p1: p1, p2: p2, abs_move: ab,
           dir_type: dt};
  endfunction : cm
  task reply_only(input string s, input at_cmd_pkg::reply_t r);
    rq.push_back(r);
    i_host.send(s);
    repeat (6) @(posedge core_clk);
  endtask : reply_only
  // the start reply is held back until the operation reports completion
  task start(input string s, input at_cmd_pkg::cmd_out_t c);
    cq.push_back(c);
    reply_only(s, rp(1'b0, 4'h0, 8'h00));
    chk("start held", 1, rq.size());
    op_done <= 1'b1;
    @(posedge core_clk);
    op_done <= 1'b0;
    repeat (5) @(posedge core_clk);
  endtask : start
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, op_done, inhibit} = '0;
    {idle, plc} = 2'b11;
    error_cnt = 0;
    checks_done = 0;
    cur = $urandom(13957);
    idx = $urandom_range(1000, 1);
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    apb(1'b0, at_cmd_pkg::CONFIG_OFS, 0);
    chk("config rst", at_cmd_pkg::CONFIG_RST, rd);
    apb(1'b0, 8'h20, 0);
    chk("unmapped", 1, re);
    chk("servo pwrup", 0, servo_on);
    reply_only("@8:1", rp(1'b1, 4'h0, at_cmd_pkg::ERR_AUTH));
    apb(1'b1, at_cmd_pkg::CONFIG_OFS, 32'h101);
    apb(1'b1, at_cmd_pkg::STORED_PROG_OFS, 32'h5);
    apb(1'b1, at_cmd_pkg::STORED_BLOCK_OFS, 32'h9);
    reply_only("!!!!!!!!!!!!!!!!!!@8:1", rp(1'b0, 4'h2, 8'h00));
    chk("servo on", 1, servo_on);
    apb(1'b0, at_cmd_pkg::STATUS_OFS, 0);
    chk("status", 32'h7, rd);
    inhibit <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk("servo inhibit", 0, servo_on);
    {inhibit, plc} <= 2'b00;
    repeat (5) @(posedge core_clk);
    chk("servo plc", 0, servo_on);
    plc <= 1'b1;
    reply_only("@8:0", rp(1'b0, 4'h0, 8'h00));
    chk("servo off", 0, servo_on);
    start("@3:4:7", cm(2, at_cmd_pkg::ACT_PROGRAM, 7, at_cmd_pkg::FIRST_BLOCK, 0, 0));
    start("@3:4", cm(1, at_cmd_pkg::ACT_PROGRAM, 5, 9, 0, 0));
    start("@3:4:7:3", cm(3, at_cmd_pkg::ACT_PROGRAM, 7, 3, 0, 0));
    foreach (acts[i]) start($sformatf("@3:%0d", acts[i]), cm(1, acts[i], 0, 0, 0, 0));
    apb(1'b1, at_cmd_pkg::CONFIG_OFS, 32'h10B);
    start($sformatf("@3:8:%0d:1", idx), cm(3, 4'h8, idx, idx, 1, 0));
    start($sformatf("@3:9:%0d", idx), cm(2, 4'h9, idx, cur + idx, 0, 0));
    start($sformatf("@3:8:%0d:0:2", idx), cm(4, 4'h8, idx, cur + idx, 0, 2));
    apb(1'b1, at_cmd_pkg::CONFIG_OFS, 32'h125);
    start($sformatf("@3:9:%0d:0:0", idx), cm(4, 4'h9, idx, idx, 1, 2));
    reply_only("@3:2", rp(1'b1, 4'h0, at_cmd_pkg::ERR_FORMAT));
    reply_only("@3:8", rp(1'b1, 4'h0, at_cmd_pkg::ERR_FORMAT));
    long_s = "";
    repeat (130) long_s = {long_s, "!"};
    reply_only({long_s, "@9"}, rp(1'b1, 4'h2, at_cmd_pkg::ERR_FORMAT));
    idle <= 1'b0;
    reply_only("@3:0", rp(1'b1, 4'h0, at_cmd_pkg::ERR_BUSY));
    idle <= 1'b1;
    apb(1'b1, at_cmd_pkg::CONFIG_OFS, 32'h181);
    // another station's frame must draw no reply at all
    i_host.send("2@3:2");
    reply_only("1!@3:2", rp(1'b1, 4'h1, at_cmd_pkg::ERR_FORMAT));
    apb(1'b1, at_cmd_pkg::CONFIG_OFS, 32'h100);
    reply_only("@3:0", rp(1'b1, 4'h0, at_cmd_pkg::ERR_AUTH));
    chk("pending", 0, rq.size() + cq.size());
    finish_test();
  end
  initial begin
    #200us;
    chk("timeout", 0, 1);
    finish_test();
  end
endmodule : tb_top
